// *** pat_pkg.sv ***
// Shared constants and types for the PWM auto-reload timer.
package pat_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_DUTY3 = 8'h73;
	localparam logic [7:0] OFS_DUTY2 = 8'h74;
	localparam logic [7:0] OFS_DUTY1 = 8'h75;
	localparam logic [7:0] OFS_DUTY0 = 8'h76;
	localparam logic [7:0] OFS_PWM_OUTPUT_CONTROL = 8'h77;
	localparam logic [7:0] OFS_CSR = 8'h78;
	localparam logic [7:0] OFS_CAR = 8'h79;
	localparam logic [7:0] OFS_ARR = 8'h7A;
	localparam logic [7:0] OFS_ICCSR = 8'h7B;
	localparam logic [7:0] OFS_ICR1 = 8'h7C;
	localparam logic [7:0] OFS_ICR2 = 8'h7D;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CSR_CLK_SEL = 7;
	localparam int CSR_CC_LO = 4;
	localparam int CSR_CNT_EN = 3;
	localparam int CSR_FRC_RLD = 2;
	localparam int CSR_OVF_IE = 1;
	localparam int CSR_OVF = 0;
	localparam int PWM_OUTPUT_CONTROL_OE_LO = 4;
	localparam int PWM_OUTPUT_CONTROL_OP_LO = 0;
	localparam int ICCSR_CS_LO = 4;
	localparam int ICCSR_CIE_LO = 2;
	localparam int ICCSR_CF_LO = 0;

	// ----------------------------------------
	// Sizes and reset values
	// ----------------------------------------
	localparam int NUM_PWM = 4;
	localparam int NUM_CAP = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] RST_PRESC = 7'h00;
	localparam logic [7:0] CNT_TOP = 8'hFF;

	// ----------------------------------------
	// Register bus request
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pat_bus_t;

endpackage : pat_pkg

// *** pat_timer.sv ***
// PWM auto-reload timer with prescaler, four PWM channels and two captures.
`timescale 1ns/1ps
// Notes on behaviour
// - Eight-bit up-counter advances once per prescaler output tick.
// - Overflow reloads counter from reload value; prescaler keeps running.
// - Prescaler divides selected input clock by two to the select code.
// - Clock source bit 7: zero CPU clock, one external clock.
// - Counter enable bit 3 low freezes both prescaler and counter.
// - Reset clears counter and prescaler and selects CPU clock.
// - Counter access write loads counter and clears prescaler; read is live.
// - Force reload bit 2 reads zero; writing one loads reload, clears prescaler.
// - Hidden compare per channel reloads from duty register on overflow.
// - Output enable bit connects each PWM output to its pin.
// - Overflow sets output by polarity; compare match restores it.
// - All channels share period of 256 minus reload counter ticks.
// - PWM generation halts while device is in halt mode.
// - Overflow sets flag bit 0; interrupt when enable bit 1 set.
// - Overflow flag clears when software reads control/status register.
// - External event mode sets flag after 256 minus reload events.
// - Selected capture edge latches counter and sets channel flag.
// - Capture register locked until read; read clears capture flag.
// - Capture interrupt stays high while flag and enable both set.
// - Each capture has own edge select and interrupt enable.
// - Enabled capture interrupt wakes device from halt.
// - Edge select zero means falling edge, one rising edge.
// - Output enable zero disables output, one enables it.
module pat_timer (
	// Clock and reset
	input logic clock,
	input logic arst_n,
	// Register port
	input pat_pkg::pat_bus_t bus_req,
	output logic [7:0] rdata,
	// Device state
	input logic halt_mode,
	// External pins
	input logic external_clock_in,
	input logic [1:0] capture_input_pin,
	output logic [3:0] pwm_output_pin,
	output logic [3:0] pwm_output_oe,
	// Interrupts and wake
	output logic ovf_irq,
	output logic [1:0] cap_irq,
	output logic wake
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic clk_sel_q;
	logic [2:0] presc_sel_q;
	logic cnt_en_q;
	logic ovf_ie_q;
	logic ovf_flag_q;
	logic [7:0] reload_q;
	logic [7:0] cnt_q;
	logic [6:0] presc_q;
	logic [3:0] oe_q;
	logic [3:0] pol_q;
	logic [7:0] duty_q [4];
	logic [7:0] ocr_q [4];
	logic [1:0] edge_sel_q;
	logic [1:0] cap_ie_q;
	logic [1:0] cap_flag_q;
	logic [7:0] icr_q [2];
	logic [3:0] pwm_act_q;

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic wr;
	logic rd;
	logic [7:0] wd;
	logic csr_wr;
	logic car_wr;
	logic frc_wr;
	logic sw_load;
	logic csr_rd;
	logic [1:0] icr_rd;

	assign wr = bus_req.wr;
	assign rd = bus_req.rd;
	assign wd = bus_req.wdata;
	assign csr_wr = wr && (bus_req.addr == pat_pkg::OFS_CSR);
	assign car_wr = wr && (bus_req.addr == pat_pkg::OFS_CAR);
	assign frc_wr = csr_wr && wd[pat_pkg::CSR_FRC_RLD];
	assign sw_load = car_wr || frc_wr;
	assign csr_rd = rd && (bus_req.addr == pat_pkg::OFS_CSR);
	assign icr_rd[0] = rd && (bus_req.addr == pat_pkg::OFS_ICR1);
	assign icr_rd[1] = rd && (bus_req.addr == pat_pkg::OFS_ICR2);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic ext_rise;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= external_clock_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// One pulse per external rising edge
	assign ext_rise = ext_s2_q && !ext_s3_q;

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------
	logic run;
	logic in_tick;
	logic [6:0] tap_mask;
	logic cnt_tick;
	logic cnt_top;
	logic ovf_evt;
	logic [7:0] cnt_nxt;

	// Halt stops prescaler and counter, so PWM freezes with the counter
	assign run = cnt_en_q && !halt_mode;
	assign in_tick = clk_sel_q ? ext_rise : 1'b1;
	assign tap_mask = 7'((8'h01 << presc_sel_q) - 8'h01);
	assign cnt_tick = run && in_tick && ((presc_q & tap_mask) == tap_mask);
	assign cnt_top = (cnt_q == pat_pkg::CNT_TOP);
	assign ovf_evt = cnt_tick && cnt_top && !sw_load;
	assign cnt_nxt = cnt_top ? reload_q : 8'(cnt_q + 8'h01);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			presc_q <= pat_pkg::RST_PRESC;
		end else if (sw_load) begin
			presc_q <= pat_pkg::RST_PRESC;
		end else if (run && in_tick) begin
			presc_q <= 7'(presc_q + 7'h01);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= pat_pkg::RST_BYTE;
		end else if (car_wr) begin
			cnt_q <= wd;
		end else if (frc_wr) begin
			cnt_q <= reload_q;
		end else if (cnt_tick) begin
			cnt_q <= cnt_nxt;
		end
	end

	// ----------------------------------------
	// Control and status register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clk_sel_q <= 1'b0;
			presc_sel_q <= 3'h0;
			cnt_en_q <= 1'b0;
			ovf_ie_q <= 1'b0;
		end else if (csr_wr) begin
			clk_sel_q <= wd[pat_pkg::CSR_CLK_SEL];
			presc_sel_q <= wd[pat_pkg::CSR_CC_LO +: 3];
			cnt_en_q <= wd[pat_pkg::CSR_CNT_EN];
			ovf_ie_q <= wd[pat_pkg::CSR_OVF_IE];
		end
	end

	// Set wins over the read-side clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovf_flag_q <= 1'b0;
		end else if (ovf_evt) begin
			ovf_flag_q <= 1'b1;
		end else if (csr_rd) begin
			ovf_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Reload and PWM control registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reload_q <= pat_pkg::RST_BYTE;
		end else if (wr && bus_req.addr == pat_pkg::OFS_ARR) begin
			reload_q <= wd;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oe_q <= 4'h0;
			pol_q <= 4'h0;
		end else if (wr && bus_req.addr == pat_pkg::OFS_PWM_OUTPUT_CONTROL) begin
			oe_q <= wd[pat_pkg::PWM_OUTPUT_CONTROL_OE_LO +: 4];
			pol_q <= wd[pat_pkg::PWM_OUTPUT_CONTROL_OP_LO +: 4];
		end
	end

	// ----------------------------------------
	// PWM channels
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pat_pkg::NUM_PWM; gi++) begin : g_pwm
			// Duty registers sit at descending offsets
			localparam logic [7:0] OFS = 8'(pat_pkg::OFS_DUTY0 - gi);

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					duty_q[gi] <= pat_pkg::RST_BYTE;
				end else if (wr && bus_req.addr == OFS) begin
					duty_q[gi] <= wd;
				end
			end

			// Double buffer keeps duty changes glitch free
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					ocr_q[gi] <= pat_pkg::RST_BYTE;
				end else if (ovf_evt) begin
					ocr_q[gi] <= duty_q[gi];
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pwm_act_q[gi] <= 1'b0;
				end else if (ovf_evt) begin
					pwm_act_q[gi] <= 1'b1;
				end else if (cnt_tick && !sw_load && cnt_nxt == ocr_q[gi]) begin
					pwm_act_q[gi] <= 1'b0;
				end
			end

			// Polarity acts at once, not at the next period
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pwm_output_pin[gi] <= 1'b0;
					pwm_output_oe[gi] <= 1'b0;
				end else begin
					pwm_output_pin[gi] <= pwm_act_q[gi] ^ pol_q[gi];
					pwm_output_oe[gi] <= oe_q[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Capture channels
	// ----------------------------------------
	logic [1:0] cap_take;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edge_sel_q <= 2'h0;
			cap_ie_q <= 2'h0;
		end else if (wr && bus_req.addr == pat_pkg::OFS_ICCSR) begin
			edge_sel_q <= wd[pat_pkg::ICCSR_CS_LO +: 2];
			cap_ie_q <= wd[pat_pkg::ICCSR_CIE_LO +: 2];
		end
	end

	generate
		for (gi = 0; gi < pat_pkg::NUM_CAP; gi++) begin : g_cap
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic hit;

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end else begin
					s1_q <= capture_input_pin[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end

			assign hit = edge_sel_q[gi] ? (s2_q && !s3_q)
				: (!s2_q && s3_q);
			// A read in the same cycle reopens the channel
			assign cap_take[gi] = hit && (!cap_flag_q[gi] || icr_rd[gi]);

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					icr_q[gi] <= pat_pkg::RST_BYTE;
				end else if (cap_take[gi]) begin
					icr_q[gi] <= cnt_q;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					cap_flag_q[gi] <= 1'b0;
				end else if (cap_take[gi]) begin
					cap_flag_q[gi] <= 1'b1;
				end else if (icr_rd[gi]) begin
					cap_flag_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Interrupts and wake
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovf_irq <= 1'b0;
			cap_irq <= 2'h0;
			wake <= 1'b0;
		end else begin
			ovf_irq <= ovf_flag_q && ovf_ie_q;
			cap_irq <= cap_flag_q & cap_ie_q;
			wake <= halt_mode && |(cap_flag_q & cap_ie_q);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = pat_pkg::RST_BYTE;
		unique case (bus_req.addr)
			pat_pkg::OFS_DUTY3: rd_mux = duty_q[3];
			pat_pkg::OFS_DUTY2: rd_mux = duty_q[2];
			pat_pkg::OFS_DUTY1: rd_mux = duty_q[1];
			pat_pkg::OFS_DUTY0: rd_mux = duty_q[0];
			pat_pkg::OFS_PWM_OUTPUT_CONTROL: rd_mux = {oe_q, pol_q};
			pat_pkg::OFS_CSR: rd_mux = {clk_sel_q, presc_sel_q, cnt_en_q,
				1'b0, ovf_ie_q, ovf_flag_q};
			pat_pkg::OFS_CAR: rd_mux = cnt_q;
			pat_pkg::OFS_ARR: rd_mux = reload_q;
			pat_pkg::OFS_ICCSR: rd_mux = {2'h0, edge_sel_q, cap_ie_q,
				cap_flag_q};
			pat_pkg::OFS_ICR1: rd_mux = icr_q[0];
			pat_pkg::OFS_ICR2: rd_mux = icr_q[1];
			default: rd_mux = pat_pkg::RST_BYTE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= pat_pkg::RST_BYTE;
		end else if (rd) begin
			rdata <= rd_mux;
		end else begin
			rdata <= pat_pkg::RST_BYTE;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_plain_tick;
		cnt_tick && !sw_load;
	endsequence

	sequence s_overflow;
		s_plain_tick ##0 cnt_top;
	endsequence

	property p_count_up;
		s_plain_tick ##0 !cnt_top |=> cnt_q == 8'($past(cnt_q) + 8'h01);
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("counter did not advance");

	property p_reload;
		s_overflow |=> cnt_q == $past(reload_q) && ovf_flag_q;
	endproperty
	a_reload: assert property (p_reload)
		else $error("overflow did not reload");

	property p_tap;
		cnt_tick |-> (presc_q & tap_mask) == tap_mask && run;
	endproperty
	a_tap: assert property (p_tap)
		else $error("tick off prescaler tap");

	property p_freeze;
		!cnt_en_q && !sw_load |=> $stable(cnt_q) && $stable(presc_q);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("counter moved while disabled");

	property p_car_write;
		car_wr |=> cnt_q == $past(wd) && presc_q == pat_pkg::RST_PRESC;
	endproperty
	a_car_write: assert property (p_car_write)
		else $error("counter write lost");

	property p_force;
		frc_wr && !car_wr |=> cnt_q == $past(reload_q)
			&& presc_q == pat_pkg::RST_PRESC;
	endproperty
	a_force: assert property (p_force)
		else $error("force reload failed");

	property p_ocr;
		s_overflow |=> ocr_q[0] == $past(duty_q[0])
			&& ocr_q[3] == $past(duty_q[3]);
	endproperty
	a_ocr: assert property (p_ocr)
		else $error("compare not refreshed");

	property p_halt;
		halt_mode |-> !cnt_tick;
	endproperty
	a_halt: assert property (p_halt)
		else $error("counting during halt");

	property p_ovf_irq;
		s_overflow ##1 ovf_ie_q |=> ovf_irq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq)
		else $error("overflow irq missing");

	property p_ovf_clear;
		csr_rd && !ovf_evt |=> !ovf_flag_q;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear)
		else $error("overflow flag not cleared");

	property p_capture;
		cap_take[0] |=> cap_flag_q[0] && icr_q[0] == $past(cnt_q);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture not latched");

	property p_cap_lock;
		cap_flag_q[1] && !icr_rd[1] |=> $stable(icr_q[1]);
	endproperty
	a_cap_lock: assert property (p_cap_lock)
		else $error("capture overwritten");

	property p_cap_irq;
		(cap_flag_q[0] && cap_ie_q[0]) [*2] |-> cap_irq[0];
	endproperty
	a_cap_irq: assert property (p_cap_irq)
		else $error("capture irq dropped");

endmodule : pat_timer

// *** pat_pin_model.sv ***
// Model of the pins around the timer: event clock source and capture lines.
`timescale 1ns/1ps
module pat_pin_model (
	// Clock
	input wire logic clock,
	// Pins driven toward the timer
	output logic external_clock_in,
	output logic [1:0] capture_input_pin
);

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Event clock stands still low between bursts
	initial begin
		external_clock_in = 1'b0;
		capture_input_pin = 2'b10;
	end

	// Three-cycle high and four-cycle low phases so the synchroniser sees every edge
	task automatic ext_pulse(input int n);
		repeat (n) begin
			@(posedge clock);
			external_clock_in <= 1'b1;
			repeat (3) @(posedge clock);
			external_clock_in <= 1'b0;
			repeat (3) @(posedge clock);
		end
		#1;
	endtask : ext_pulse

	task automatic cap_drive(input logic [1:0] v);
		@(posedge clock);
		capture_input_pin <= v;
		repeat (5) @(posedge clock);
		#1;
	endtask : cap_drive

endmodule : pat_pin_model

// *** pat_timer_test.sv ***
// Self-checking testbench for the PWM auto-reload timer.
`timescale 1ns/1ps
module pat_timer_test;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock;
	logic arst_n;
	pat_pkg::pat_bus_t bus_req;
	logic [7:0] rdata;
	logic halt_mode;
	logic external_clock_in;
	logic [1:0] capture_input_pin;
	logic [3:0] pwm_output_pin;
	logic [3:0] pwm_output_oe;
	logic ovf_irq;
	logic [1:0] cap_irq;
	logic wake;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] got;
	logic [7:0] first;

	pat_timer dut (
		.clock(clock),
		.arst_n(arst_n),
		.bus_req(bus_req),
		.rdata(rdata),
		.halt_mode(halt_mode),
		.external_clock_in(external_clock_in),
		.capture_input_pin(capture_input_pin),
		.pwm_output_pin(pwm_output_pin),
		.pwm_output_oe(pwm_output_oe),
		.ovf_irq(ovf_irq),
		.cap_irq(cap_irq),
		.wake(wake)
	);

	pat_pin_model mdl (
		.clock(clock),
		.external_clock_in(external_clock_in),
		.capture_input_pin(capture_input_pin)
	);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Whole run needs a few thousand cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus_req <= '0;
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus_req <= '0;
		#1 d = rdata;
		@(posedge clock);
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		rd(a, got);
		check(got, e);
	endtask : rdchk

	// Rise to rise of one PWM pin, sampled clear of the edges
	task automatic pwm_measure(input int ch, input int hi_e, input int per_e);
		int n;
		int hi;
		n = 0;
		hi = 0;
		while (pwm_output_pin[ch] !== 1'b0 && n < 600) begin
			@(posedge clock);
			#1 n++;
		end
		while (pwm_output_pin[ch] !== 1'b1 && n < 600) begin
			@(posedge clock);
			#1 n++;
		end
		n = 0;
		while (pwm_output_pin[ch] === 1'b1 && n < 600) begin
			@(posedge clock);
			#1 n++;
			hi++;
		end
		while (pwm_output_pin[ch] === 1'b0 && n < 600) begin
			@(posedge clock);
			#1 n++;
		end
		check(8'(hi), 8'(hi_e));
		check(8'(n), 8'(per_e));
	endtask : pwm_measure

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		for (int a = 8'h72; a <= 8'h7E; a++) begin
			rdchk(8'(a), 8'h00);
		end
		$display("test reset done");
	endtask : test_reset

	task automatic test_regs();
		wr(pat_pkg::OFS_ARR, 8'h5A);
		rdchk(pat_pkg::OFS_ARR, 8'h5A);
		wr(pat_pkg::OFS_ICCSR, 8'hFF);
		rdchk(pat_pkg::OFS_ICCSR, 8'h3C);
		wr(pat_pkg::OFS_ICR1, 8'h55);
		rdchk(pat_pkg::OFS_ICR1, 8'h00);
		wr(8'h7E, 8'h11);
		rdchk(8'h7E, 8'h00);
		wr(pat_pkg::OFS_CSR, 8'h04);
		rdchk(pat_pkg::OFS_CSR, 8'h00);
		rdchk(pat_pkg::OFS_CAR, 8'h5A);
		wr(pat_pkg::OFS_ICCSR, 8'h00);
		$display("test registers done");
	endtask : test_regs

	// Enabled for exactly 200 edges, then frozen
	task automatic test_count();
		for (int n = 0; n < 8; n++) begin
			wr(pat_pkg::OFS_CAR, 8'h00);
			wr(pat_pkg::OFS_CSR, {1'b0, 3'(n), 4'h8});
			repeat (198) @(posedge clock);
			wr(pat_pkg::OFS_CSR, {1'b0, 3'(n), 4'h0});
			rd(pat_pkg::OFS_CAR, first);
			check(first, 8'(200 >> n));
			repeat (5) @(posedge clock);
			rdchk(pat_pkg::OFS_CAR, first);
		end
		$display("test counting done");
	endtask : test_count

	task automatic test_pwm();
		wr(pat_pkg::OFS_ARR, 8'hF0);
		wr(pat_pkg::OFS_DUTY0, 8'hF8);
		wr(pat_pkg::OFS_DUTY1, 8'hF4);
		wr(pat_pkg::OFS_DUTY2, 8'hF2);
		wr(pat_pkg::OFS_DUTY3, 8'hFC);
		wr(pat_pkg::OFS_PWM_OUTPUT_CONTROL, 8'hF6);
		wr(pat_pkg::OFS_CSR, 8'h0E);
		check({4'h0, pwm_output_oe}, 8'h0F);
		pwm_measure(0, 8, 16);
		pwm_measure(1, 12, 16);
		pwm_measure(2, 14, 16);
		pwm_measure(3, 12, 16);
		wr(pat_pkg::OFS_CSR, 8'h02);
		repeat (3) @(posedge clock);
		check({7'h00, ovf_irq}, 8'h01);
		rdchk(pat_pkg::OFS_CSR, 8'h03);
		rdchk(pat_pkg::OFS_CSR, 8'h02);
		check({7'h00, ovf_irq}, 8'h00);
		$display("test pwm done");
	endtask : test_pwm

	task automatic test_event();
		wr(pat_pkg::OFS_ARR, 8'hFD);
		wr(pat_pkg::OFS_CSR, 8'h8C);
		mdl.ext_pulse(2);
		repeat (4) @(posedge clock);
		rdchk(pat_pkg::OFS_CSR, 8'h88);
		mdl.ext_pulse(1);
		repeat (4) @(posedge clock);
		rdchk(pat_pkg::OFS_CSR, 8'h89);
		rdchk(pat_pkg::OFS_CAR, 8'hFD);
		wr(pat_pkg::OFS_CSR, 8'h00);
		$display("test event done");
	endtask : test_event

	task automatic test_capture();
		wr(pat_pkg::OFS_CAR, 8'h37);
		wr(pat_pkg::OFS_ICCSR, 8'h1C);
		mdl.cap_drive(2'b11);
		check({6'h00, cap_irq}, 8'h01);
		rdchk(pat_pkg::OFS_ICCSR, 8'h1D);
		wr(pat_pkg::OFS_CAR, 8'h50);
		mdl.cap_drive(2'b10);
		mdl.cap_drive(2'b11);
		halt_mode <= 1'b1;
		repeat (3) @(posedge clock);
		#1 check({7'h00, wake}, 8'h01);
		rdchk(pat_pkg::OFS_ICR1, 8'h37);
		rdchk(pat_pkg::OFS_ICCSR, 8'h1C);
		check({6'h00, cap_irq}, 8'h00);
		check({7'h00, wake}, 8'h00);
		mdl.cap_drive(2'b00);
		check({6'h00, cap_irq}, 8'h02);
		rdchk(pat_pkg::OFS_ICR2, 8'h50);
		rdchk(pat_pkg::OFS_ICCSR, 8'h1C);
		halt_mode <= 1'b0;
		$display("test capture done");
	endtask : test_capture

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	initial begin
		arst_n = 1'b0;
		halt_mode = 1'b0;
		bus_req = '0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		test_reset();
		test_regs();
		test_count();
		test_pwm();
		test_event();
		test_capture();
		stop_test();
	end

endmodule : pat_timer_test
